// >>> dv/srap_host.sv
// host controller model driving the four-wire serial port
`timescale 1ns/1ns
`default_nettype none

module srap_host (
  // serial pins towards the device
  output logic select_n,
  output logic sclk,
  output logic serial_in,
  // answer from the device
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // half period of the 800 ns link clock
  localparam int HALF = 400;

  // idle: deselected, clock parked low
  initial begin
    select_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end

  // ****************************************************************
  // one frame of n bits, cut short after cut bits when cut < n
  // ****************************************************************
  task automatic frame(input int n, input int cut, input logic [24:0] tx,
                       output logic [24:0] rx, output logic oe_seen);
    rx = '0;
    oe_seen = 1'b0;
    select_n = 1'b0;
    #(HALF);
    for (int i = n - 1; i >= n - cut; i--) begin
      serial_in = tx[i]; // msb first, set while clock low
      #(HALF);
      // sample just before the rise, as the device promises stability here
      rx = {rx[23:0], serial_out};
      oe_seen = oe_seen | serial_out_oe;
      sclk = 1'b1;
      #(HALF);
      sclk = 1'b0;
    end
    // a released data line must not keep showing its last bit
    serial_in = ~serial_in;
    #(HALF);
    select_n = 1'b1; // deselect after every frame
    #(HALF * 2);
  endtask
endmodule // srap_host

`default_nettype wire

// >>> dv/srap_tb_top.sv
// self-checking testbench of the serial register access port
`timescale 1ns/1ns
`default_nettype none

module srap_tb_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic mclk;
  logic rst;
  logic clk_en;
  logic select_n;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic frame_mode_strap;
  logic identity_strap;
  logic rx_clk_in;
  logic rx_clk_out;
  logic diff_rx_powerdown_n;
  int err_count = 0;
  int cmp_count = 0;

  // 10 MHz system clock
  always #50 mclk = ~mclk;

  // device under test
  srap_top srap_top_inst (
    .mclk(mclk), .rst(rst), .clk_en(clk_en),
    .select_n(select_n), .sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .frame_mode_strap(frame_mode_strap), .identity_strap(identity_strap),
    .rx_clk_in(rx_clk_in), .rx_clk_out(rx_clk_out),
    .diff_rx_powerdown_n(diff_rx_powerdown_n)
  );

  // far-side host
  srap_host srap_host_inst (
    .select_n(select_n), .sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // counts, verdict, end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // wait n edges, then step just past the edge
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // straps change only while deselected, with settle time for the synchronisers
  task automatic straps(input logic m, input logic id);
    ticks(1);
    frame_mode_strap = m;
    identity_strap = id;
    ticks(8);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // outputs quiet after reset; receiver starts powered down
  task automatic t_reset;
    check("pd_n at reset", {15'h0, diff_rx_powerdown_n}, 16'h0000);
    check("oe at reset", {15'h0, serial_out_oe}, 16'h0000);
    $display("test reset done");
  endtask

  // 25-cycle frames: identity match, abort, power-down bit
  task automatic t_mode25;
    logic [24:0] rx;
    logic oe;
    straps(1'b0, 1'b1);
    rx_clk_in = 1'b1; // the modelled receiver settles at once; a short wait stands
    srap_host_inst.frame(25, 25, {1'b0, 1'b1, 7'h70, 16'h0002}, rx, oe);
    ticks(6);
    check("pd_n after write", {15'h0, diff_rx_powerdown_n}, 16'h0001);
    check("rx clock passed", {15'h0, rx_clk_out}, 16'h0001);
    check("oe in write", {15'h0, oe}, 16'h0000);
    // wrong identity bit: write must be dropped, read must not drive
    srap_host_inst.frame(25, 25, {1'b0, 1'b0, 7'h70, 16'h0000}, rx, oe);
    ticks(6);
    check("pd_n after foreign write", {15'h0, diff_rx_powerdown_n}, 16'h0001);
    srap_host_inst.frame(25, 25, {1'b1, 1'b0, 7'h70, 16'h0000}, rx, oe);
    check("oe in foreign read", {15'h0, oe}, 16'h0000);
    // aborted frame, then a full read must still line up
    srap_host_inst.frame(25, 5, {1'b0, 1'b1, 7'h70, 16'h0000}, rx, oe);
    srap_host_inst.frame(25, 25, {1'b1, 1'b1, 7'h70, 16'h0000}, rx, oe);
    check("read after abort", rx[15:0], 16'h0002);
    check("oe in read", {15'h0, oe}, 16'h0001);
    ticks(6);
    check("oe after deselect", {15'h0, serial_out_oe}, 16'h0000);
    srap_host_inst.frame(25, 25, {1'b0, 1'b1, 7'h70, 16'h0000}, rx, oe);
    ticks(6);
    check("pd_n cleared", {15'h0, diff_rx_powerdown_n}, 16'h0000);
    check("rx clock stopped", {15'h0, rx_clk_out}, 16'h0000);
    $display("test mode25 done");
  endtask

  // 24-cycle frames: write and read back a full word
  task automatic t_mode24;
    logic [24:0] rx;
    logic oe;
    straps(1'b1, 1'b0);
    srap_host_inst.frame(24, 24, {2'b00, 7'h05, 16'ha5c3}, rx, oe);
    srap_host_inst.frame(24, 24, {2'b01, 7'h05, 16'h0000}, rx, oe);
    check("word read", rx[15:0], 16'ha5c3);
    $display("test mode24 done");
  endtask

  // 8-bit indirect access, read formats, then word view in 24-cycle mode
  task automatic t_mode16;
    logic [24:0] rx;
    logic oe;
    logic [2:0] wa [3] = '{3'b001, 3'b010, 3'b100};
    logic [7:0] wd [3] = '{8'h05, 8'hfc, 8'h9e};
    logic [1:0] rf [5] = '{2'b01, 2'b01, 2'b00, 2'b11, 2'b01};
    logic [2:0] ra [5] = '{3'b001, 3'b010, 3'b100, 3'b100, 3'b011};
    logic [7:0] re [5] = '{8'h05, 8'hfc, 8'h1e, 8'h9e, 8'h00};
    straps(1'b1, 1'b1);
    // address, low byte, high byte completes the write
    for (int i = 0; i < 3; i++) begin
      srap_host_inst.frame(16, 16, {9'h0, 2'b00, 1'b0, wa[i], 2'b00, wd[i]}, rx, oe);
    end
    // reads in formats 00, 01 and 11, one unmapped number
    for (int i = 0; i < 5; i++) begin
      srap_host_inst.frame(16, 16, {9'h0, rf[i], 1'b1, ra[i], 2'b00, 8'h00}, rx, oe);
      check("byte read", {8'h00, rx[7:0]}, {8'h00, re[i]});
    end
    straps(1'b1, 1'b0);
    srap_host_inst.frame(24, 24, {2'b01, 7'h05, 16'h0000}, rx, oe);
    check("indirect word", rx[15:0], 16'h9efc);
    $display("test mode16 done");
  endtask

  // clock enable low freezes the port; a mid-run reset restores every default
  task automatic t_freeze_reset;
    logic [24:0] rx;
    logic oe;
    clk_en = 1'b0;
    srap_host_inst.frame(24, 24, {2'b00, 7'h70, 16'h0002}, rx, oe);
    ticks(6);
    check("pd_n while frozen", {15'h0, diff_rx_powerdown_n}, 16'h0000);
    clk_en = 1'b1;
    ticks(4);
    srap_host_inst.frame(24, 24, {2'b00, 7'h70, 16'h0002}, rx, oe);
    ticks(6);
    check("pd_n after thaw", {15'h0, diff_rx_powerdown_n}, 16'h0001);
    rst = 1'b1;
    ticks(3);
    rst = 1'b0;
    check("pd_n after reset", {15'h0, diff_rx_powerdown_n}, 16'h0000);
    check("rx clock after reset", {15'h0, rx_clk_out}, 16'h0000);
    check("oe after reset", {15'h0, serial_out_oe}, 16'h0000);
    ticks(8);
    srap_host_inst.frame(24, 24, {2'b01, 7'h05, 16'h0000}, rx, oe);
    check("word cleared by reset", rx[15:0], 16'h0000);
    $display("test freeze_reset done");
  endtask

  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    frame_mode_strap = 1'b0;
    identity_strap = 1'b1;
    rx_clk_in = 1'b0;
    ticks(3);
    rst = 1'b0;
    ticks(8);
    t_reset;
    t_mode25;
    t_mode24;
    t_mode16;
    t_freeze_reset;
    close_out;
  end

  // a run far beyond the expected length counts as a hang
  initial begin
    #(3_000_000);
    err_count++;
    close_out;
  end
endmodule // srap_tb_top

`default_nettype wire

// >>> include/srap_map.svh
// constants of the serial register access port: lengths, field positions, offsets, resets
`ifndef SRAP_MAP_SVH
`define SRAP_MAP_SVH

// ****************************************************************
// frame lengths in serial clock cycles
// ****************************************************************
`define SRAP_LEN_25 5'd25
`define SRAP_LEN_24 5'd24
`define SRAP_LEN_16 5'd16

// header lengths: bits before the data phase
`define SRAP_HDR_25 5'd9
`define SRAP_HDR_24 5'd8
`define SRAP_HDR_16 5'd8

// ****************************************************************
// header field positions, counted in the shift register after the header
// ****************************************************************
`define SRAP_H25_DIR 8
`define SRAP_H25_IDSEL 7
`define SRAP_H24_DIR 7
`define SRAP_H16_FMT_HI 7
`define SRAP_H16_FMT_LO 6
`define SRAP_H16_DIR 5
`define SRAP_H16_SUB_HI 4
`define SRAP_H16_SUB_LO 2

// ****************************************************************
// indirect register numbers and read format
// ****************************************************************
`define SRAP_IND_ADDR 3'b001
`define SRAP_IND_LOW 3'b010
`define SRAP_IND_HIGH 3'b100
`define SRAP_FMT_NARROW 2'b00

// ****************************************************************
// register file
// ****************************************************************
`define SRAP_REG_COUNT 128
`define SRAP_ANALOG_IDX 7'h70
`define SRAP_PD_BIT 1
`define SRAP_ANALOG_RST 16'h0000
`define SRAP_WORD_RST 16'h0000
`define SRAP_BYTE_RST 8'h00

`endif

// >>> include/srap_pkg.sv
// types shared by the serial register access port
package srap_pkg;

  // ****************************************************************
  // frame length mode, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    srap_m25 = 3'b001,  // 16-bit access with identity bit
    srap_m24 = 3'b010,  // 16-bit access without identity bit
    srap_m16 = 3'b100   // 8-bit indirect access
  } srap_mode_e;

  // ****************************************************************
  // frame phase, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    srap_hdr = 3'b001,   // collecting header bits
    srap_data = 3'b010,  // data phase of an accepted frame
    srap_skip = 3'b100   // frame ignored or finished, wait for deselect
  } srap_phase_e;

endpackage

// >>> src/srap_sync.sv
// two-flop synchronisers for the pins sampled by mclk
`timescale 1ns/1ns
`default_nettype none

module srap_sync (
  // clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // raw pins and synchronised copies
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_sync
);

  // ****************************************************************
  // one synchroniser per pin
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_bit
      logic meta_reg;  // first stage, read only by the second
      logic sync_reg;  // second stage, safe to use
      always_ff @(posedge mclk) begin
        if (rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else if (clk_en) begin
          meta_reg <= pin_in[g];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync[g] = sync_reg;
    end
  endgenerate

endmodule // srap_sync

`default_nettype wire

// >>> src/srap_top.sv
// serial register access port with register file and receiver power-down control
`timescale 1ns/1ns
`default_nettype none
`include "srap_map.svh"

module srap_top import srap_pkg::*; (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // four-wire serial port
  input wire logic select_n,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // straps
  input wire logic frame_mode_strap,
  input wire logic identity_strap,
  // differential receiver
  input wire logic rx_clk_in,
  output logic rx_clk_out,
  output logic diff_rx_powerdown_n
);

  // ****************************************************************
  // synchronised pins and edge detect
  // ****************************************************************
  logic [5:0] pin_sync;  // select, sclk, data, two straps, rx clock
  logic sel_s, sck_s, sdi_s, frame_mode_strap_s, id_s, rxc_s;
  logic sck_prev_reg;  // last sampled sclk level
  logic sck_rise;      // one mclk pulse per sclk rising edge

  srap_sync srap_sync_inst (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in({rx_clk_in, identity_strap, frame_mode_strap, serial_in, sclk, select_n}),
    .pin_sync(pin_sync)
  );

  assign {rxc_s, id_s, frame_mode_strap_s, sdi_s, sck_s, sel_s} = pin_sync;
  assign sck_rise = sck_s & ~sck_prev_reg;

  always_ff @(posedge mclk) begin
    if (rst) sck_prev_reg <= 1'b0;
    else if (clk_en) sck_prev_reg <= sck_s;
  end

  // ****************************************************************
  // state
  // ****************************************************************
  srap_mode_e mode_reg;     // frame length chosen while deselected
  srap_phase_e phase_reg;   // where the frame stands
  logic [4:0] cnt_reg;      // bits received in this frame
  logic [23:0] sh_reg;      // incoming bits, msb first
  logic dir_reg;            // 1 = read
  logic [6:0] idx_reg;      // direct register number
  logic [2:0] sub_reg;      // indirect register number
  logic [15:0] out_sh_reg;  // outgoing read word
  logic so_reg;             // serial out level
  logic oe_reg;             // serial out enable
  logic [7:0] addr_reg;     // indirect address
  logic [7:0] dlow_reg;     // indirect low byte
  // the high byte feeds the committed word directly, so it keeps no register of its own
  logic [15:0] analog_reg;  // analog control word
  logic rxo_reg;            // gated receiver clock
  logic [15:0] mem [`SRAP_REG_COUNT];  // general registers

  // ****************************************************************
  // frame decode
  // ****************************************************************
  logic [4:0] hdr_len, frame_len, cnt_next;
  logic [23:0] sh_next;
  logic hdr_done, frame_done, hdr_ok, hdr_dir;
  logic [6:0] hdr_idx;
  logic [1:0] hdr_fmt;
  logic [2:0] hdr_sub;

  assign sh_next = {sh_reg[22:0], sdi_s};    // msb arrives first
  assign cnt_next = 5'(cnt_reg + 5'd1);
  assign hdr_done = sck_rise && (phase_reg == srap_hdr) && (cnt_next == hdr_len);
  assign frame_done = sck_rise && (phase_reg == srap_data) && (cnt_next == frame_len);

  // header fields as they stand on the rise that ends the header
  always_comb begin
    hdr_len = `SRAP_HDR_24;
    frame_len = `SRAP_LEN_24;
    hdr_ok = 1'b1;
    hdr_dir = sh_next[`SRAP_H24_DIR];
    hdr_idx = sh_next[6:0];
    hdr_fmt = sh_next[`SRAP_H16_FMT_HI:`SRAP_H16_FMT_LO];
    hdr_sub = sh_next[`SRAP_H16_SUB_HI:`SRAP_H16_SUB_LO];
    unique case (mode_reg)
      srap_m25: begin
        hdr_len = `SRAP_HDR_25;
        frame_len = `SRAP_LEN_25;
        hdr_dir = sh_next[`SRAP_H25_DIR];
        hdr_ok = (sh_next[`SRAP_H25_IDSEL] == id_s);
      end
      srap_m24: begin
        hdr_len = `SRAP_HDR_24;
        frame_len = `SRAP_LEN_24;
      end
      srap_m16: begin
        hdr_len = `SRAP_HDR_16;
        frame_len = `SRAP_LEN_16;
        hdr_dir = sh_next[`SRAP_H16_DIR];
      end
      default: hdr_ok = 1'b0;  // illegal code: ignore the frame
    endcase
  end

  // ****************************************************************
  // frame length from the straps, taken only while deselected
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) mode_reg <= srap_m25;
    else if (clk_en && sel_s) begin
      if (!frame_mode_strap_s) mode_reg <= srap_m25;
      else if (!id_s) mode_reg <= srap_m24;
      else mode_reg <= srap_m16;
    end
  end

  // ****************************************************************
  // bit counter and input shifter
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= 5'd0;
      sh_reg <= 24'h000000;
    end else if (clk_en) begin
      if (sel_s) begin
        cnt_reg <= 5'd0;
        sh_reg <= 24'h000000;
      end else if (sck_rise && cnt_reg != frame_len) begin
        cnt_reg <= cnt_next;  // extra clocks past the frame are dropped
        sh_reg <= sh_next;
      end
    end
  end

  // ****************************************************************
  // phase and latched header
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_reg <= srap_hdr;
      dir_reg <= 1'b0;
      idx_reg <= 7'h00;
      sub_reg <= 3'b000;
    end else if (clk_en) begin
      if (sel_s) phase_reg <= srap_hdr;
      else begin
        unique case (phase_reg)
          srap_hdr: if (hdr_done) begin
            phase_reg <= hdr_ok ? srap_data : srap_skip;
            dir_reg <= hdr_dir;
            idx_reg <= hdr_idx;
            sub_reg <= hdr_sub;
          end
          srap_data: if (frame_done) phase_reg <= srap_skip;
          srap_skip: phase_reg <= srap_skip;
          default: phase_reg <= srap_skip;
        endcase
      end
    end
  end

  // ****************************************************************
  // write path
  // ****************************************************************
  logic frame_wr, wr_en;
  logic [6:0] wr_idx;
  logic [15:0] wr_data;
  logic is_m16;

  assign is_m16 = (mode_reg == srap_m16);
  assign frame_wr = frame_done && !dir_reg;
  // 8-bit mode commits only when the high byte lands
  assign wr_en = frame_wr && (!is_m16 || sub_reg == `SRAP_IND_HIGH);
  assign wr_idx = is_m16 ? addr_reg[6:0] : idx_reg;
  assign wr_data = is_m16 ? {sh_next[7:0], dlow_reg} : sh_next[15:0];

  // indirect byte registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_reg <= `SRAP_BYTE_RST;
      dlow_reg <= `SRAP_BYTE_RST;
    end else if (clk_en && frame_wr && is_m16) begin
      if (sub_reg == `SRAP_IND_ADDR) addr_reg <= sh_next[7:0];
      if (sub_reg == `SRAP_IND_LOW) dlow_reg <= sh_next[7:0];
    end
  end

  // general register array; the analog word lives apart so it always has a value
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < `SRAP_REG_COUNT; i++) mem[i] <= `SRAP_WORD_RST;
    end else if (clk_en && wr_en) mem[wr_idx] <= wr_data;
  end

  always_ff @(posedge mclk) begin
    if (rst) analog_reg <= `SRAP_ANALOG_RST;
    else if (clk_en && wr_en && wr_idx == `SRAP_ANALOG_IDX) analog_reg <= wr_data;
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [6:0] rd_idx;
  logic [15:0] rd_word, rd_load;
  logic [7:0] rd_byte;

  assign rd_idx = is_m16 ? addr_reg[6:0] : hdr_idx;
  assign rd_word = (rd_idx == `SRAP_ANALOG_IDX) ? analog_reg : mem[rd_idx];

  always_comb begin
    rd_byte = `SRAP_BYTE_RST;
    if (hdr_sub == `SRAP_IND_ADDR) rd_byte = addr_reg;
    else if (hdr_sub == `SRAP_IND_LOW) rd_byte = rd_word[7:0];
    else if (hdr_sub == `SRAP_IND_HIGH) rd_byte = rd_word[15:8];
    if (hdr_fmt == `SRAP_FMT_NARROW) rd_byte[7:6] = 2'b00;
    rd_load = is_m16 ? {rd_byte, `SRAP_BYTE_RST} : rd_word;
  end

  // ****************************************************************
  // serial out: loaded at header end, shifted after each rise
  // ****************************************************************
  logic load_rd;
  assign load_rd = hdr_done && hdr_ok && hdr_dir;

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_sh_reg <= `SRAP_WORD_RST;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (clk_en) begin
      if (sel_s) begin
        oe_reg <= 1'b0;
        so_reg <= 1'b0;
      end else if (load_rd) begin
        out_sh_reg <= rd_load;
        so_reg <= rd_load[15];  // first bit set up well before next rise
        oe_reg <= 1'b1;
      end else if (sck_rise && oe_reg && phase_reg == srap_data) begin
        out_sh_reg <= {out_sh_reg[14:0], 1'b0};
        so_reg <= out_sh_reg[14];  // host has sampled the old bit on this rise
      end
    end
  end

  // ****************************************************************
  // receiver clock gating
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) rxo_reg <= 1'b0;
    else if (clk_en) rxo_reg <= rxc_s & analog_reg[`SRAP_PD_BIT];
  end

  assign serial_out = so_reg;
  assign serial_out_oe = oe_reg;
  assign rx_clk_out = rxo_reg;
  assign diff_rx_powerdown_n = analog_reg[`SRAP_PD_BIT];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_deselect;
    clk_en && sel_s;
  endsequence

  sequence s_hdr_read_ok;
    clk_en && !sel_s && hdr_done && hdr_ok && hdr_dir;
  endsequence

  chk_counter_clear: assert property (s_deselect |=> cnt_reg == 5'd0)
    else $error("bit counter not cleared while deselected");
  chk_out_idle: assert property (s_deselect |=> !serial_out_oe)
    else $error("serial out driven while deselected");
  chk_oe_read_only: assert property (serial_out_oe |-> dir_reg && phase_reg != srap_hdr)
    else $error("serial out driven outside a read data phase");
  chk_skip_no_write: assert property (phase_reg == srap_skip |=>
      $stable(analog_reg) && $stable(addr_reg) && $stable(dlow_reg))
    else $error("write taken in an ignored frame");
  chk_mode_straps: assert property (s_deselect ##1 (clk_en && sel_s) |->
      mode_reg == (!$past(frame_mode_strap_s) ? srap_m25 : (!$past(id_s) ? srap_m24 : srap_m16)))
    else $error("frame mode does not follow the straps");
  chk_frame_len: assert property (frame_done |->
      cnt_next == (!frame_mode_strap_s ? `SRAP_LEN_25 : (!id_s ? `SRAP_LEN_24 : `SRAP_LEN_16)))
    else $error("frame ended at the wrong bit count");
  chk_pd_write: assert property (clk_en && wr_en && wr_idx == `SRAP_ANALOG_IDX |=>
      diff_rx_powerdown_n == $past(wr_data[`SRAP_PD_BIT]))
    else $error("power-down bit not written");
  chk_rx_gated: assert property (clk_en && !diff_rx_powerdown_n |=> !rx_clk_out)
    else $error("receiver clock passes while powered down");
  chk_read_start: assert property (s_hdr_read_ok |=> serial_out_oe && serial_out == $past(rd_load[15]))
    else $error("read data not presented after header");
  chk_narrow_fmt: assert property ((s_hdr_read_ok and
      (is_m16 && hdr_fmt == `SRAP_FMT_NARROW)) |=> out_sh_reg[15:14] == 2'b00 && !serial_out)
    else $error("narrow format upper bits not zero");
  chk_out_stable: assert property (serial_out_oe && !sel_s && !sck_rise |=> $stable(serial_out))
    else $error("serial out changed between sclk rises");
  chk_ind_commit: assert property (frame_wr && is_m16 && sub_reg == `SRAP_IND_HIGH |->
      wr_en && wr_idx == addr_reg[6:0] && wr_data[7:0] == dlow_reg)
    else $error("indirect write did not commit to addressed register");

endmodule // srap_top

`default_nettype wire
